//--- core/adcs_cfg.svh
// Constants of the one-shot sweep sequencer.
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH
`define ADCS_WSEL_2 2'h0
`define ADCS_WSEL_4 2'h1
`define ADCS_WSEL_6 2'h2
`define ADCS_WSEL_8 2'h3
`define ADCS_GSEL_LOW 2'h0
`define ADCS_GSEL_HIGH 2'h1
`define ADCS_BASE_LOW 4'h0
`define ADCS_BASE_HIGH 4'h8
`define ADCS_SRC_SW 2'h0
`define ADCS_SRC_TIMER 2'h1
`define ADCS_SRC_EXT 2'h2
`define ADCS_RESULT_RST 10'h000
`define ADCS_IDX_RST 3'h0
`endif

//--- core/adcs_pkg.sv
// Types shared by the one-shot sweep sequencer.
package adcs_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} adcs_state_e;
  typedef struct packed {
    logic [1:0] input_group_select;
    logic [1:0] sweep_width_select;
    logic res10;
    logic [1:0] trig_src;
  } adcs_cfg_s;
  typedef logic [7:0][9:0] adcs_res_t;
endpackage

//--- core/adcs_trig.sv
// Start source selection and external trigger synchroniser.
`timescale 1ns/1ps
`include "adcs_cfg.svh"
module adcs_trig
  import adcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Sources
  input wire logic [1:0] src_in,
  input wire logic sw_start_in,
  input wire logic timer_trig_in,
  input wire logic ext_trig_in,
  // Request
  output logic start_req_out
);
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_rise;

  // The pin is asynchronous, so only the second and third stages feed the edge detector.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_trig_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  assign ext_rise = ext_s2_r & ~ext_s3_r;

  always_comb begin
    start_req_out = 1'b0;
    if (src_in == `ADCS_SRC_SW) begin
      start_req_out = sw_start_in;
    end else if (src_in == `ADCS_SRC_TIMER) begin
      start_req_out = timer_trig_in;
    end else if (src_in == `ADCS_SRC_EXT) begin
      start_req_out = ext_rise;
    end
  end
endmodule

//--- core/adcs_sweep.sv
// One-shot sweep sequencer: walks an input group once and fills the result registers.
//
// Behaviour
// - Convert each group input exactly once per trigger.
// - Start from software, timer or external trigger.
// - Clear running flag after last input converts.
// - Software clearing running flag halts the sweep.
// - One interrupt request when whole group completes.
// - Group and width select channels 0-1,8-9,0-3,8-11,0-5,0-7.
// - Result register index follows channel low position.
`timescale 1ns/1ps
`include "adcs_cfg.svh"
module adcs_sweep
  import adcs_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Configuration, to be changed only while stopped
  input wire adcs_cfg_s CFG_IN,
  // Software writes to the running flag
  input wire logic RUN_WRITE1_IN,
  input wire logic RUN_WRITE0_IN,
  // Hardware start sources
  input wire logic TIMER_TRIG_IN,
  input wire logic EXT_TRIG_IN,
  // Conversion core handshake
  output logic CONV_START_OUT,
  output logic CONV_ABORT_OUT,
  output logic [3:0] CONV_CHAN_OUT,
  input wire logic CONV_DONE_IN,
  input wire logic [9:0] CONV_DATA_IN,
  // Status and results
  output logic RUN_FLAG_OUT,
  output logic IRQ_OUT,
  output adcs_res_t RESULTS_OUT
);
  adcs_state_e state_r;
  adcs_cfg_s cfg_r;
  logic [2:0] idx_r;
  logic run_r;
  logic irq_r;
  logic start_req;
  logic trig;
  logic abort;
  logic done_ok;
  logic last;
  adcs_res_t results_r;

  // Number of inputs in the group.
  function automatic logic [3:0] width_of(input logic [1:0] wsel);
    logic [3:0] w;
    w = 4'h8;
    if (wsel == `ADCS_WSEL_2) begin
      w = 4'h2;
    end else if (wsel == `ADCS_WSEL_4) begin
      w = 4'h4;
    end else if (wsel == `ADCS_WSEL_6) begin
      w = 4'h6;
    end
    return w;
  endfunction

  // First channel; the high group exists only for widths two and four.
  function automatic logic [3:0] base_of(input adcs_cfg_s c);
    logic [3:0] b;
    b = `ADCS_BASE_LOW;
    if (c.input_group_select == `ADCS_GSEL_HIGH &&
        (c.sweep_width_select == `ADCS_WSEL_2 || c.sweep_width_select == `ADCS_WSEL_4)) begin
      b = `ADCS_BASE_HIGH;
    end
    return b;
  endfunction

  // Eight-bit mode keeps the upper eight bits, right justified.
  function automatic logic [9:0] justify(input logic [9:0] d, input logic res10);
    return res10 ? d : {2'h0, d[9:2]};
  endfunction

  adcs_trig u_trig (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .src_in(CFG_IN.trig_src),
    .sw_start_in(RUN_WRITE1_IN),
    .timer_trig_in(TIMER_TRIG_IN),
    .ext_trig_in(EXT_TRIG_IN),
    .start_req_out(start_req)
  );

  // A trigger during a sweep is ignored; a sweep runs to its end once.
  assign trig = start_req & (state_r == ST_IDLE);
  // A clear is ignored while idle, so a clear only ends a live sweep.
  assign abort = RUN_WRITE0_IN & (state_r != ST_IDLE);
  assign done_ok = (state_r == ST_WAIT) & CONV_DONE_IN & ~abort;
  assign last = ({1'b0, idx_r} == width_of(cfg_r.sweep_width_select) - 4'h1);
  assign CONV_START_OUT = (state_r == ST_START) & ~abort;
  assign CONV_ABORT_OUT = abort;
  assign RUN_FLAG_OUT = run_r;
  assign IRQ_OUT = irq_r;
  assign RESULTS_OUT = results_r;

  // Sequencing of the group.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_r <= ST_IDLE;
      idx_r <= `ADCS_IDX_RST;
      cfg_r <= '0;
      CONV_CHAN_OUT <= 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (trig) begin
            cfg_r <= CFG_IN;
            idx_r <= `ADCS_IDX_RST;
            CONV_CHAN_OUT <= base_of(CFG_IN);
            state_r <= ST_START;
          end
        end
        ST_START: begin
          state_r <= abort ? ST_IDLE : ST_WAIT;
        end
        ST_WAIT: begin
          if (abort) begin
            state_r <= ST_IDLE;
          end else if (CONV_DONE_IN) begin
            if (last) begin
              state_r <= ST_IDLE;
            end else begin
              idx_r <= idx_r + 3'h1;
              CONV_CHAN_OUT <= CONV_CHAN_OUT + 4'h1;
              state_r <= ST_START;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Running flag and completion request.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      run_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irq_r <= done_ok & last;
      if (trig) begin
        run_r <= 1'b1;
      end else if (abort) begin
        run_r <= 1'b0;
      end else if (done_ok && last) begin
        run_r <= 1'b0;
      end
    end
  end

  // Result storage; the register index is the position within the group.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < 8; i++) begin
        results_r[i] <= `ADCS_RESULT_RST;
      end
    end else if (done_ok) begin
      results_r[idx_r] <= justify(CONV_DATA_IN, cfg_r.res10);
    end
  end

  // Helper count of conversions started in the current sweep.
  logic [3:0] starts_r;
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      starts_r <= 4'h0;
    end else if (state_r == ST_IDLE) begin
      starts_r <= 4'h0;
    end else if (CONV_START_OUT) begin
      starts_r <= starts_r + 4'h1;
    end
  end

  a_count_at_end: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    IRQ_OUT |-> starts_r == width_of(cfg_r.sweep_width_select))
    else $error("sweep did not convert each input once");

  a_trigger_starts: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    trig |=> RUN_FLAG_OUT && (CONV_START_OUT || CONV_ABORT_OUT) &&
      CONV_CHAN_OUT == base_of($past(CFG_IN)))
    else $error("trigger did not start the sweep");

  a_last_clears: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (done_ok && last) |=> !RUN_FLAG_OUT && IRQ_OUT ##1 !IRQ_OUT)
    else $error("running flag not cleared at end of sweep");

  a_abort_halts: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (abort ##1 !trig) |-> (!RUN_FLAG_OUT && !IRQ_OUT && !CONV_START_OUT) [*2])
    else $error("sweep continued after software stop");

  a_irq_only_end: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    IRQ_OUT |-> $past(state_r) == ST_WAIT && $past(CONV_DONE_IN) && $past(last) &&
      !$past(RUN_WRITE0_IN))
    else $error("interrupt without completed group");

  a_group_range: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    CONV_START_OUT |-> CONV_CHAN_OUT >= base_of(cfg_r) &&
      CONV_CHAN_OUT < base_of(cfg_r) + width_of(cfg_r.sweep_width_select))
    else $error("channel outside selected group");

  a_result_stored: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    done_ok |=> results_r[$past(idx_r)] == justify($past(CONV_DATA_IN), cfg_r.res10))
    else $error("result not stored in its register");

  a_ascending_next: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (done_ok && !last) |=> CONV_CHAN_OUT == $past(CONV_CHAN_OUT) + 4'h1 && state_r == ST_START)
    else $error("next input not in ascending order");

  a_eight_bit: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (done_ok && !cfg_r.res10) |=> results_r[$past(idx_r)][9:8] == 2'h0)
    else $error("eight bit result not justified");
endmodule

//--- bench/adcs_conv_model.sv
// Behavioural conversion core that answers the sweep sequencer.
`timescale 1ns/1ps
module adcs_conv_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Requests from the sequencer
  input wire logic conv_start_in,
  input wire logic conv_abort_in,
  input wire logic [3:0] conv_chan_in,
  // Bench knobs: data salt and answer delay
  input wire logic [5:0] salt_in,
  input wire logic [3:0] delay_in,
  // Answer
  output logic conv_done_out,
  output logic [9:0] conv_data_out
);
  logic busy_r;
  logic [3:0] cnt_r;
  logic [3:0] chan_r;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      chan_r <= 4'h0;
      conv_done_out <= 1'b0;
      conv_data_out <= 10'h3ff;
    end else begin
      conv_done_out <= 1'b0;
      // Data is only valid with done, so it toggles otherwise to expose late sampling.
      conv_data_out <= ~conv_data_out;
      if (conv_abort_in) begin
        busy_r <= 1'b0;
      end else if (conv_start_in) begin
        busy_r <= 1'b1;
        cnt_r <= delay_in;
        chan_r <= conv_chan_in;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        conv_done_out <= 1'b1;
        conv_data_out <= {chan_r, salt_in};
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

//--- bench/adcs_sweep_tb.sv
// Self-checking bench for the one-shot sweep sequencer.
`timescale 1ns/1ps
`include "adcs_cfg.svh"
module adcs_sweep_tb;
  import adcs_pkg::*;
  logic CLK_IN = 1'b0, RESET_IN = 1'b1, RUN_WRITE1_IN = 1'b0, RUN_WRITE0_IN = 1'b0;
  logic TIMER_TRIG_IN = 1'b0, EXT_TRIG_IN = 1'b0, CONV_START_OUT, CONV_ABORT_OUT;
  logic CONV_DONE_IN, RUN_FLAG_OUT, IRQ_OUT;
  logic [3:0] CONV_CHAN_OUT, exp_chan = 4'h0, delay = 4'h0;
  logic [9:0] CONV_DATA_IN;
  logic [5:0] salt = 6'h00;
  logic [1:0] gs[6] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};
  logic [1:0] ws[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  adcs_cfg_s cfg = '0;
  adcs_res_t RESULTS_OUT;
  int seed = 64531, n_errors = 0, tests_run = 0, nstart = 0, nirq = 0;
  always #50 CLK_IN = ~CLK_IN;
  adcs_sweep DUT (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .CFG_IN(cfg),
    .RUN_WRITE1_IN(RUN_WRITE1_IN), .RUN_WRITE0_IN(RUN_WRITE0_IN),
    .TIMER_TRIG_IN(TIMER_TRIG_IN), .EXT_TRIG_IN(EXT_TRIG_IN),
    .CONV_START_OUT(CONV_START_OUT), .CONV_ABORT_OUT(CONV_ABORT_OUT),
    .CONV_CHAN_OUT(CONV_CHAN_OUT), .CONV_DONE_IN(CONV_DONE_IN), .CONV_DATA_IN(CONV_DATA_IN),
    .RUN_FLAG_OUT(RUN_FLAG_OUT), .IRQ_OUT(IRQ_OUT), .RESULTS_OUT(RESULTS_OUT));
  adcs_conv_model PEER (.clk_in(CLK_IN), .reset_in(RESET_IN), .conv_start_in(CONV_START_OUT),
    .conv_abort_in(CONV_ABORT_OUT), .conv_chan_in(CONV_CHAN_OUT), .salt_in(salt),
    .delay_in(delay), .conv_done_out(CONV_DONE_IN), .conv_data_out(CONV_DATA_IN));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task must(input bit ok);
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask
  // Eight-bit mode keeps the top bits, right-justified.
  function automatic logic [9:0] exp_res(input logic [3:0] ch, input logic r10);
    return r10 ? {ch, salt} : {2'h0, ch, salt[5:2]};
  endfunction
  always @(negedge CLK_IN) begin
    delay <= 4'($unsigned($random(seed)) % 6);
    if (CONV_START_OUT) begin
      check(CONV_CHAN_OUT, exp_chan);
      exp_chan = exp_chan + 4'h1;
      nstart++;
    end
    if (IRQ_OUT)
      nirq++;
  end
  task pulse_src(input logic [1:0] s);
    @(negedge CLK_IN);
    RUN_WRITE1_IN = (s == `ADCS_SRC_SW) || (s == 2'h3);
    TIMER_TRIG_IN = (s == `ADCS_SRC_TIMER) || (s == 2'h3);
    EXT_TRIG_IN = (s == `ADCS_SRC_EXT) || (s == 2'h3);
    @(negedge CLK_IN);
    {RUN_WRITE1_IN, TIMER_TRIG_IN, EXT_TRIG_IN} = 3'h0;
  endtask
  task sweep(input logic [1:0] g, input logic [1:0] w, input logic [1:0] s, input bit ab);
    int i, n;
    logic [3:0] base;
    n = 2 * (w + 1);
    base = (g == `ADCS_GSEL_HIGH && w < 2) ? `ADCS_BASE_HIGH : `ADCS_BASE_LOW;
    cfg = '{g, w, 1'($random(seed)), s};
    salt = 6'($random(seed));
    {nstart, nirq} = 0;
    exp_chan = base;
    pulse_src(s);
    for (i = 0; i < 10 && !RUN_FLAG_OUT; i++)
      @(negedge CLK_IN);
    must(RUN_FLAG_OUT === 1'b1);
    if (ab) begin
      for (i = 0; i < 200 && nstart < 3; i++)
        @(negedge CLK_IN);
      must(nstart >= 3);
      RUN_WRITE0_IN = 1'b1;
      #1 check(CONV_ABORT_OUT, 1'b1);
      @(negedge CLK_IN);
      RUN_WRITE0_IN = 1'b0;
      check(RUN_FLAG_OUT, 1'b0);
      repeat (20) @(negedge CLK_IN);
      check(nirq, 0);
      // A clear while stopped has nothing to halt.
      RUN_WRITE0_IN = 1'b1;
      #1 check(CONV_ABORT_OUT, 1'b0);
      @(negedge CLK_IN);
      RUN_WRITE0_IN = 1'b0;
      return;
    end
    for (i = 0; i < 500 && RUN_FLAG_OUT; i++) begin
      @(negedge CLK_IN);
      // A second trigger while running must not restart the group.
      RUN_WRITE1_IN = (i == 2) && RUN_FLAG_OUT;
      TIMER_TRIG_IN = (i == 2) && RUN_FLAG_OUT;
    end
    must(i < 500);
    repeat (2) @(negedge CLK_IN);
    check(nstart, n);
    check(nirq, 1);
    for (i = 0; i < n; i++)
      check(RESULTS_OUT[i], exp_res(base + 4'(i), cfg.res10));
  endtask
  initial begin
    repeat (10) @(negedge CLK_IN);
    RESET_IN = 1'b0;
    check(RUN_FLAG_OUT, 1'b0);
    check(IRQ_OUT, 1'b0);
    check(RESULTS_OUT[0], `ADCS_RESULT_RST);
    for (int k = 0; k < 18; k++)
      sweep(gs[k % 6], ws[k % 6], 2'(k / 6), 1'b0);
    sweep(2'h0, 2'h3, `ADCS_SRC_TIMER, 1'b1);
    sweep(2'h1, 2'h1, `ADCS_SRC_EXT, 1'b0);
    // The high group does not exist for six inputs, so the low group is walked.
    sweep(2'h1, 2'h2, `ADCS_SRC_SW, 1'b0);
    cfg.trig_src = 2'h3;
    nstart = 0;
    pulse_src(2'h3);
    repeat (6) @(negedge CLK_IN);
    check(RUN_FLAG_OUT, 1'b0);
    check(nstart, 0);
    tally_and_finish();
  end
endmodule
